// ===== logic/boot_cal_core.sv
// embedded core boot sequencer and calibration command front end
`timescale 1ns/1ps
`include "boot_cal_regs.svh"
module boot_cal_core (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire sysref,
   output logic [31:0] rdata,
   output logic irq,
   output logic clk_synth_en,
   output logic framer_en,
   output logic deframer_en,
   output logic clocks_aligned,
   output logic cal_start,
   output logic cal_loopback,
   output logic [3:0] cal_sel,
   output logic [3:0] path_en
);
   boot_cal_pkg::core_state_t state;
   boot_cal_pkg::core_state_t next_state;
   boot_cal_pkg::segment_t segment;
   boot_cal_pkg::cal_cmd_t cmd_in;
   logic [31:0] fw_mem [0:`FW_WORDS-1];
   logic [31:0] data_mem [0:`DATA_WORDS-1];
   logic [15:0] fw_wptr;
   logic [15:0] data_wptr;
   logic [15:0] boot_ptr;
   logic [7:0] step_cnt;
   logic [31:0] fw_word;
   logic [31:0] fw_sum;
   logic [31:0] stream_sum;
   logic [31:0] profile_sum;
   logic [`IRQ_BITS-1:0] irq_status;
   logic [`IRQ_BITS-1:0] irq_mask;
   logic [`IRQ_BITS-1:0] irq_set;
   logic [`IRQ_BITS-1:0] next_irq_status;
   logic sysref_s1;
   logic sysref_s2;
   logic sysref_s3;
   logic sysref_edge;
   logic load_done;
   logic sync_req;
   logic pair_legal;
   logic pair_loopback;
   logic cmd_ready;
   logic cal_hit;
   logic step_done;
   logic boot_last;
   logic [31:0] next_rdata;
   logic [7:0] state_code;
   logic wr_ctl;
   logic wr_fw;
   logic wr_data;
   logic wr_cal;
   logic wr_irq_clr;
   logic wr_mask;
   logic wr_path;
   logic stream_add;
   logic profile_add;
   logic in_reset;
   logic fw_take;
   logic data_take;
   logic ctl_restart;
   logic boot_done;
   logic sum_add;
   logic cal_bad;
   logic cal_early;
   logic [`IRQ_BITS-1:0] next_irq_mask;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = a == r;
   endfunction

   // one write strobe per register, decoded once
   assign wr_ctl = wr && hit(addr, `ADDR_CONTROL);
   assign wr_fw = wr && hit(addr, `ADDR_FW_DATA);
   assign wr_data = wr && hit(addr, `ADDR_DATA_MEM);
   assign wr_cal = wr && hit(addr, `ADDR_CAL_CMD);
   assign wr_irq_clr = wr && hit(addr, `ADDR_IRQ_STATUS);
   assign wr_mask = wr && hit(addr, `ADDR_IRQ_MASK);
   assign wr_path = wr && hit(addr, `ADDR_PATH_EN);
   assign cmd_in = boot_cal_pkg::cal_cmd_t'(wdata[8:0]);

   assign in_reset = state == boot_cal_pkg::st_reset;
   assign ctl_restart = wr_ctl && wdata[`CTL_RESTART];
   // only the state-0 window takes image words
   assign load_done = wr_ctl && wdata[`CTL_LOAD_DONE] && in_reset;
   // pointers stop one past the top, so a full image is still summed
   assign fw_take = wr_fw && in_reset
      && fw_wptr != 16'(`FW_WORDS);
   assign data_take = wr_data && in_reset
      && data_wptr != 16'(`DATA_WORDS);
   // sync is armed from ready only; a sysref during boot is ignored
   assign sync_req = wr_ctl && !wdata[`CTL_RESTART]
      && wdata[`CTL_SYNC] && state == boot_cal_pkg::st_ready;

   // first sysref flop feeds only the second
   assign sysref_edge = sysref_s2 && !sysref_s3;

   assign step_done = step_cnt == 8'(`BOOT_STEP_CYC - 1);
   assign boot_last = boot_ptr == fw_wptr;
   assign boot_done = state == boot_cal_pkg::st_boot_sum && boot_last;
   assign sum_add = state == boot_cal_pkg::st_boot_sum && !boot_last;
   assign fw_word = fw_mem[boot_ptr[15:0]];

   assign cmd_ready = state == boot_cal_pkg::st_ready
      || state == boot_cal_pkg::st_synced;
   assign cal_hit = wr_cal && cmd_ready && pair_legal;
   // rejected and early commands leave cal_sel and the route untouched
   assign cal_bad = wr_cal && cmd_ready && !pair_legal;
   assign cal_early = wr_cal && !cmd_ready;

   feedback_checker u_pair (
      .cmd(cmd_in),
      .legal(pair_legal),
      .use_loopback(pair_loopback)
   );

   // streams and profiles are summed as they are written into data memory
   assign stream_add = data_take && segment == boot_cal_pkg::seg_stream;
   assign profile_add = data_take && segment == boot_cal_pkg::seg_profile;

   // firmware is summed at boot, one stored word per cycle
   checksum_unit u_fw_sum (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(load_done),
      .add(sum_add),
      .word(fw_word),
      .sum(fw_sum)
   );

   checksum_unit u_stream_sum (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(1'b0),
      .add(stream_add),
      .word(wdata),
      .sum(stream_sum)
   );

   checksum_unit u_profile_sum (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(1'b0),
      .add(profile_add),
      .word(wdata),
      .sum(profile_sum)
   );

   // restart wins over every other transition, from any state
   always_comb begin
      next_state = state;
      case (state)
         boot_cal_pkg::st_reset: begin
            if (load_done) begin
               next_state = boot_cal_pkg::st_boot_clk;
            end
         end
         boot_cal_pkg::st_boot_clk: begin
            if (step_done) begin
               next_state = boot_cal_pkg::st_boot_sum;
            end
         end
         boot_cal_pkg::st_boot_sum: begin
            if (boot_last) begin
               next_state = boot_cal_pkg::st_ready;
            end
         end
         boot_cal_pkg::st_ready: begin
            if (sync_req) begin
               next_state = boot_cal_pkg::st_sync;
            end
         end
         boot_cal_pkg::st_sync: begin
            if (sysref_edge) begin
               next_state = boot_cal_pkg::st_synced;
            end
         end
         boot_cal_pkg::st_synced: begin
            next_state = boot_cal_pkg::st_synced;
         end
         default: begin
            next_state = boot_cal_pkg::st_reset;
         end
      endcase
      if (ctl_restart) begin
         next_state = boot_cal_pkg::st_reset;
      end
   end

   // software sees only the two documented core states; synced reads as ready, every other state reads 8'hFF
   assign state_code = state == boot_cal_pkg::st_reset ? `STATE_RESET_CODE :
      cmd_ready ? `STATE_READY_CODE : 8'hFF;

   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_READY] = boot_done;
      irq_set[`IRQ_SYNCED] = state == boot_cal_pkg::st_sync && sysref_edge;
      irq_set[`IRQ_PAIR_BAD] = cal_bad;
      irq_set[`IRQ_CAL_IGNORED] = cal_early;
      irq_set[`IRQ_CAL_DONE] = cal_hit;
   end

   // a fresh event beats a simultaneous write-one clear
   assign next_irq_status = (irq_status & ~(wr_irq_clr ?
      wdata[`IRQ_BITS-1:0] : '0)) | irq_set;

   // irq follows a mask write at the same edge, not one cycle late
   assign next_irq_mask = wr_mask ? wdata[`IRQ_BITS-1:0] : irq_mask;

   // rdata is zero outside the read response cycle
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            `ADDR_CONTROL: next_rdata = {30'h0, segment};
            `ADDR_STATUS: next_rdata = {26'h0, state, clk_synth_en,
               framer_en, deframer_en};
            `ADDR_FW_SUM: next_rdata = fw_sum;
            `ADDR_STREAM_SUM: next_rdata = stream_sum;
            `ADDR_PROFILE_SUM: next_rdata = profile_sum;
            `ADDR_IRQ_STATUS: next_rdata = {27'h0, irq_status};
            `ADDR_IRQ_MASK: next_rdata = {27'h0, irq_mask};
            `ADDR_PATH_EN: next_rdata = {28'h0, path_en};
            `ADDR_CORE_STATE: next_rdata = {24'h0, state_code};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // memories carry no reset; contents are only meaningful once loaded
   always_ff @(posedge ref_clk) begin
      if (fw_take) begin
         fw_mem[fw_wptr] <= wdata;
      end
      if (data_take) begin
         data_mem[data_wptr] <= wdata;
      end
   end

   // third flop only feeds the edge detector
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sysref_s1 <= 1'b0;
         sysref_s2 <= 1'b0;
         sysref_s3 <= 1'b0;
      end else begin
         sysref_s1 <= sysref;
         sysref_s2 <= sysref_s1;
         sysref_s3 <= sysref_s2;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= boot_cal_pkg::st_reset;
         step_cnt <= 8'h00;
         boot_ptr <= 16'h0000;
      end else begin
         state <= next_state;
         // boot_clk dwell lets the synthesizer settle before the framers
         step_cnt <= state == boot_cal_pkg::st_boot_clk ?
            step_cnt + 8'h01 : 8'h00;
         boot_ptr <= state == boot_cal_pkg::st_boot_sum && !boot_last ?
            boot_ptr + 16'h0001 : 16'h0000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fw_wptr <= 16'h0000;
         data_wptr <= 16'h0000;
         segment <= boot_cal_pkg::seg_firmware;
      end else begin
         if (ctl_restart) begin
            fw_wptr <= 16'h0000;
            data_wptr <= 16'h0000;
         end else begin
            if (fw_take) begin
               fw_wptr <= fw_wptr + 16'h0001;
            end
            if (data_take) begin
               data_wptr <= data_wptr + 16'h0001;
            end
         end
         if (wr_ctl && in_reset) begin
            segment <= boot_cal_pkg::segment_t'(wdata[2:1]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_synth_en <= 1'b0;
         framer_en <= 1'b0;
         deframer_en <= 1'b0;
         clocks_aligned <= 1'b0;
      end else begin
         // framers wait for the device clock, one state behind the synth
         clk_synth_en <= state != boot_cal_pkg::st_reset;
         framer_en <= state != boot_cal_pkg::st_reset
            && state != boot_cal_pkg::st_boot_clk;
         deframer_en <= state != boot_cal_pkg::st_reset
            && state != boot_cal_pkg::st_boot_clk;
         clocks_aligned <= state == boot_cal_pkg::st_synced;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_start <= 1'b0;
         cal_loopback <= 1'b0;
         cal_sel <= 4'h0;
      end else begin
         // one pulse per accepted command
         cal_start <= cal_hit;
         if (cal_hit) begin
            cal_loopback <= pair_loopback;
            cal_sel <= cmd_in.cal;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
         path_en <= 4'h0;
         rdata <= 32'h0000_0000;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & next_irq_mask);
         irq_mask <= next_irq_mask;
         // no calibration gate on the path enables
         if (wr_path) begin
            path_en <= wdata[3:0];
         end
         rdata <= next_rdata;
      end
   end
endmodule // boot_cal_core

// ===== inc/boot_cal_regs.svh
// constants for the embedded core boot and calibration feedback block
`ifndef BOOT_CAL_REGS_SVH
`define BOOT_CAL_REGS_SVH
`define FW_MEM_BYTES 229376
`define DATA_MEM_BYTES 163840
`define FW_WORDS 57344
`define DATA_WORDS 40960
`define STATE_RESET_CODE 8'h00
`define STATE_READY_CODE 8'h01
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_FW_DATA 8'h08
`define ADDR_FW_SUM 8'h0C
`define ADDR_STREAM_SUM 8'h10
`define ADDR_PROFILE_SUM 8'h14
`define ADDR_CAL_CMD 8'h18
`define ADDR_IRQ_STATUS 8'h1C
`define ADDR_IRQ_MASK 8'h20
`define ADDR_DATA_MEM 8'h24
`define ADDR_PATH_EN 8'h28
`define ADDR_CORE_STATE 8'h2C
`define CTL_LOAD_DONE 0
`define CTL_SEGMENT_LSB 1
`define CTL_RESTART 3
`define CTL_SYNC 4
`define IRQ_READY 0
`define IRQ_SYNCED 1
`define IRQ_PAIR_BAD 2
`define IRQ_CAL_IGNORED 3
`define IRQ_CAL_DONE 4
`define IRQ_BITS 5
`define BOOT_STEP_NS 100
`define BOOT_STEP_CYC ((`BOOT_STEP_NS + 9) / 10)
`endif

// ===== inc/boot_cal_pkg.sv
// types shared by the boot and calibration feedback block
package boot_cal_pkg;
   typedef enum logic [2:0] {
      st_reset = 3'b000,
      st_boot_clk = 3'b001,
      st_boot_sum = 3'b011,
      st_ready = 3'b010,
      st_sync = 3'b110,
      st_synced = 3'b111
   } core_state_t;
   typedef enum logic [1:0] {
      seg_firmware = 2'b00,
      seg_stream = 2'b01,
      seg_profile = 2'b10
   } segment_t;
   typedef struct packed {
      logic [1:0] tx;
      logic [1:0] obs;
      logic external;
      logic [3:0] cal;
   } cal_cmd_t;
   typedef struct packed {
      logic clk_synth_en;
      logic framer_en;
      logic deframer_en;
   } boot_cfg_t;
endpackage

// ===== logic/feedback_checker.sv
// same-side feedback pairing check for transmitter calibrations
`timescale 1ns/1ps
module feedback_checker (
   input wire boot_cal_pkg::cal_cmd_t cmd,
   output logic legal,
   output logic use_loopback
);
   function automatic logic side_of(input logic [1:0] ch);
      side_of = ch[1];
   endfunction
   // tx1/2 pair with receiver 1/2, tx3/4 with 3/4
   assign legal = side_of(cmd.tx) == side_of(cmd.obs);
   // leakage cals take the external wire, the rest loop back inside
   assign use_loopback = !cmd.external;
endmodule // feedback_checker

// ===== logic/checksum_unit.sv
// running checksum over one loaded segment
`timescale 1ns/1ps
module checksum_unit (
   input wire ref_clk,
   input wire rst_n,
   input wire clear,
   input wire add,
   input wire [31:0] word,
   output logic [31:0] sum
);
   logic [31:0] next_sum;
   // rotate-add so swapped words still change the sum
   assign next_sum = clear ? 32'h0000_0000 :
      add ? {sum[30:0], sum[31]} + word : sum;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sum <= 32'h0000_0000;
      end else begin
         sum <= next_sum;
      end
   end
endmodule // checksum_unit

// ===== bench/boot_cal_core_assertions.sv
// port-level checker for the boot and calibration core
`timescale 1ns/1ps
module boot_cal_core_assertions (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire sysref,
   input wire [31:0] rdata,
   input wire irq,
   input wire clk_synth_en,
   input wire framer_en,
   input wire deframer_en,
   input wire clocks_aligned,
   input wire cal_start,
   input wire cal_loopback,
   input wire [3:0] cal_sel,
   input wire [3:0] path_en
);
   // cycles since sysref was last seen high, saturating
   logic [3:0] age;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) age <= 4'hF;
      else if (sysref) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_cal_from_write: assert property (
      cal_start |-> $past(wr && addr == 8'h18))
      else $error("calibration start without a command write");
   a_cal_same_side: assert property (
      cal_start |-> $past(wdata[8]) == $past(wdata[6]))
      else $error("calibration started on a cross-side pairing");
   a_tx4_far_rejected: assert property (
      $past(wr && addr == 8'h18 && wdata[8:7] == 2'h3 && !wdata[6])
      |-> !cal_start)
      else $error("transmitter 4 fed to receiver 1 or 2 was accepted");
   a_cal_route_kind: assert property (
      cal_start |-> cal_loopback == !$past(wdata[4]))
      else $error("loopback choice does not follow external bit");
   a_cal_code_kept: assert property (
      cal_start |-> cal_sel == $past(wdata[3:0]))
      else $error("calibration code differs from command");
   a_cal_needs_boot: assert property (
      cal_start |-> clk_synth_en)
      else $error("calibration started before boot");
   a_framers_on_clock: assert property (
      (framer_en || deframer_en) |-> clk_synth_en)
      else $error("framers enabled without the clock synthesizer");
   a_align_after_sysref: assert property (
      $rose(clocks_aligned) |-> age <= 4'h8)
      else $error("clocks aligned without a recent sysref");
   a_path_write: assert property (
      $past(wr && addr == 8'h28) |-> path_en == $past(wdata[3:0]))
      else $error("path enables not taken from write");
endmodule // boot_cal_core_assertions

bind boot_cal_core boot_cal_core_assertions chk (.ref_clk, .rst_n,
   .addr, .wdata, .wr, .rd, .sysref, .rdata, .irq, .clk_synth_en,
   .framer_en, .deframer_en, .clocks_aligned, .cal_start,
   .cal_loopback, .cal_sel, .path_en);

// ===== bench/host_model.sv
// host controller model on the register port, with sysref source
`timescale 1ns/1ps
module host_model (
   input wire ref_clk,
   input wire irq,
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd,
   output logic sysref
);
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      sysref = 1'b0;
   end
   // write cycle only, so a broadcast load never needs a read
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask
   task automatic get(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask
   task automatic pulse_sysref();
      @(posedge ref_clk);
      sysref <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sysref <= 1'b0;
   endtask
   // bounded boot wait, a run-out is reported as failure
   task automatic wait_irq(input int max, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < max && ok !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
         ok = irq;
      end
   endtask
endmodule // host_model

// ===== bench/testbench.sv
// self-checking bench for the boot and calibration core
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, s, w, v, p1, p2;
   logic wr, rd, sysref, irq, clk_synth_en, framer_en, deframer_en;
   logic clocks_aligned, cal_start, cal_loopback, ok, prd;
   logic [3:0] cal_sel, path_en;
   logic [31:0] rq[$];
   logic [4:0] cq[$];
   logic [31:0] seed = 32'h3205;
   int mismatches = 0;
   int total_checks = 0;
   always #5 ref_clk = ~ref_clk;
   host_model host (.ref_clk, .irq, .addr, .wdata, .wr, .rd, .sysref);
   boot_cal_core dut (.ref_clk, .rst_n, .addr, .wdata, .wr, .rd,
      .sysref, .rdata, .irq, .clk_synth_en, .framer_en, .deframer_en,
      .clocks_aligned, .cal_start, .cal_loopback, .cal_sel, .path_en);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      host.get(a);
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(posedge ref_clk);
      #1;
      check({31'h0, irq}, {31'h0, e});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // results are matched against the oldest note as they appear
   always @(posedge ref_clk) begin
      prd = rd;
      #1;
      if (prd) begin
         if (rq.size() == 0) check(32'h1, 32'h0);
         else check(rdata, rq.pop_front());
      end
      if (cal_start === 1'b1) begin
         if (cq.size() == 0) check(32'h1, 32'h0);
         else check({27'h0, cal_loopback, cal_sel}, {27'h0, cq.pop_front()});
      end
   end
   initial begin
      #50us;
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_exp(8'h2C, 32'h0);
      host.put(8'h18, 32'h1);
      rd_exp(8'h1C, 32'h8);
      host.put(8'h1C, 32'h8);
      v = rnd();
      host.put(8'h28, v);
      #1;
      check({28'h0, path_en}, {28'h0, v[3:0]});
      $display("test early commands done");
      s = 32'h0;
      for (int i = 0; i < 6; i++) begin
         w = rnd();
         host.put(8'h08, w);
         s = {s[30:0], s[31]} + w;
      end
      p1 = rnd();
      p2 = rnd();
      host.put(8'h00, 32'h2);
      host.put(8'h24, p1);
      host.put(8'h00, 32'h4);
      host.put(8'h24, p2);
      host.put(8'h20, 32'h1F);
      host.put(8'h00, 32'h1);
      rd_exp(8'h2C, 32'hFF);
      host.wait_irq(200, ok);
      check({31'h0, ok}, 32'h1);
      rd_exp(8'h2C, 32'h1);
      rd_exp(8'h0C, s);
      rd_exp(8'h10, p1);
      rd_exp(8'h14, p2);
      rd_exp(8'h04, 32'h17);
      rd_exp(8'h1C, 32'h1);
      host.put(8'h1C, 32'h1);
      irq_is(1'b0);
      host.put(8'h08, rnd());
      rd_exp(8'h0C, s);
      rd_exp(8'hFC, 32'h0);
      $display("test boot done");
      // every transmitter against every receiver
      for (int i = 0; i < 16; i++) begin
         v = rnd();
         w = {23'h0, i[3:2], i[1:0], v[4:0]};
         if (i[3] == i[1]) cq.push_back({~v[4], v[3:0]});
         host.put(8'h18, w);
      end
      rd_exp(8'h1C, 32'h14);
      host.put(8'h1C, 32'h14);
      $display("test feedback pairing done");
      host.put(8'h00, 32'h10);
      host.pulse_sysref();
      for (int n = 0; n < 20 && clocks_aligned !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      check({31'h0, clocks_aligned}, 32'h1);
      rd_exp(8'h1C, 32'h2);
      irq_is(1'b1);
      host.put(8'h20, 32'h0);
      irq_is(1'b0);
      host.put(8'h20, 32'h2);
      irq_is(1'b1);
      host.put(8'h1C, 32'h2);
      irq_is(1'b0);
      $display("test sync and interrupt done");
      host.put(8'h00, 32'h8);
      rd_exp(8'h2C, 32'h0);
      host.put(8'h18, 32'h5);
      rd_exp(8'h1C, 32'h8);
      repeat (3) @(posedge ref_clk);
      check(32'(rq.size() + cq.size()), 32'h0);
      $display("test restart done");
      wrap_up();
   end
endmodule // testbench
